/* File: core/icr_init_config.sv */
// init config bank: regulator_setup and watchdog_setup registers and the logic they steer
// assumes a decoded spi write strobe and register address, analog comparator flags synchronous to clk_sys_i
`timescale 1ns/1ps
`include "icr_map.svh"

module icr_init_config #(
    parameter int unsigned HOLD_0_CYC = `ICR_US_TO_CYC(`ICR_HOLD_0_US),
    parameter int unsigned HOLD_1_CYC = `ICR_US_TO_CYC(`ICR_HOLD_1_US),
    parameter int unsigned HOLD_2_CYC = `ICR_US_TO_CYC(`ICR_HOLD_2_US),
    parameter int unsigned HOLD_3_CYC = `ICR_US_TO_CYC(`ICR_HOLD_3_US),
    parameter int unsigned CYC_0_CYC  = `ICR_US_TO_CYC(`ICR_CYC_0_US),
    parameter int unsigned CYC_1_CYC  = `ICR_US_TO_CYC(`ICR_CYC_1_US),
    parameter int unsigned CYC_2_CYC  = `ICR_US_TO_CYC(`ICR_CYC_2_US),
    parameter int unsigned CYC_3_CYC  = `ICR_US_TO_CYC(`ICR_CYC_3_US)
) (
    // clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       rst_i,
    // register access from the spi command decoder
    input  wire logic       init_mode_i,
    input  wire logic       reg_wr_i,
    input  wire logic [4:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    output logic      [7:0] reg_rdata_o,
    output logic            reg_hit_o,
    // cyclic sense
    input  wire logic       cyclic_en_i,
    input  wire logic       cyclic_start_i,
    input  wire logic       wake_io_one_i,
    output logic            wake_io_zero_o,
    output logic            wake_io_one_sample_o,
    // undervoltage monitor
    input  wire logic       uv_below_hi_i,
    input  wire logic       uv_below_lo_i,
    output logic            uv_irq_o,
    output logic            system_reset_out_n_o,
    // aux regulator and watchdog options
    output logic            aux_supply_5v_o,
    output logic      [7:0] watchdog_setup_o
);
    localparam int unsigned CNT_W = 24;

    // refused at elaboration: a length the down-counters cannot hold
    if (HOLD_3_CYC == 0 || CYC_0_CYC == 0 ||
        HOLD_0_CYC >= (1 << CNT_W) || HOLD_1_CYC >= (1 << CNT_W) ||
        HOLD_2_CYC >= (1 << CNT_W) || HOLD_3_CYC >= (1 << CNT_W) ||
        CYC_0_CYC >= (1 << CNT_W) || CYC_1_CYC >= (1 << CNT_W) ||
        CYC_2_CYC >= (1 << CNT_W) || CYC_3_CYC >= (1 << CNT_W))
    begin : g_bad_count
        $error("icr_init_config: count parameter out of range");
    end

    function automatic logic [CNT_W-1:0] hold_len(input logic [1:0] sel);
        case (sel)
            2'b00:   hold_len = CNT_W'(HOLD_0_CYC);
            2'b01:   hold_len = CNT_W'(HOLD_1_CYC);
            2'b10:   hold_len = CNT_W'(HOLD_2_CYC);
            default: hold_len = CNT_W'(HOLD_3_CYC);
        endcase
    endfunction : hold_len

    function automatic logic [CNT_W-1:0] cyc_len(input logic [1:0] sel);
        case (sel)
            2'b00:   cyc_len = CNT_W'(CYC_0_CYC);
            2'b01:   cyc_len = CNT_W'(CYC_1_CYC);
            2'b10:   cyc_len = CNT_W'(CYC_2_CYC);
            default: cyc_len = CNT_W'(CYC_3_CYC);
        endcase
    endfunction : cyc_len

    // ========================================
    // registers
    logic [7:0] regulator_setup;
    logic [7:0] watchdog_setup;
    logic [7:0] next_regulator_setup;
    logic [7:0] next_watchdog_setup;
    logic [7:0] next_rdata;

    always_comb
    begin
        next_regulator_setup = regulator_setup;
        next_watchdog_setup  = watchdog_setup;
        // outside init mode the write is dropped silently
        if (reg_wr_i && init_mode_i)
        begin
            if (reg_addr_i == `ICR_ADDR_REG_SETUP)
                next_regulator_setup = reg_wdata_i;
            if (reg_addr_i == `ICR_ADDR_WDOG_SETUP)
                next_watchdog_setup = reg_wdata_i;
        end
        case (reg_addr_i)
            `ICR_ADDR_REG_SETUP:  next_rdata = regulator_setup;
            `ICR_ADDR_WDOG_SETUP: next_rdata = watchdog_setup;
            default:              next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            regulator_setup <= `ICR_RST_REG_SETUP;
            watchdog_setup  <= `ICR_RST_WDOG_SETUP;
            reg_rdata_o     <= 8'h00;
        end
        else
        begin
            regulator_setup <= next_regulator_setup;
            watchdog_setup  <= next_watchdog_setup;
            reg_rdata_o     <= next_rdata;
        end
    end

    assign reg_hit_o        = (reg_addr_i == `ICR_ADDR_REG_SETUP) || (reg_addr_i == `ICR_ADDR_WDOG_SETUP);
    assign watchdog_setup_o = watchdog_setup;
    assign aux_supply_5v_o  = regulator_setup[`ICR_AUX_V_BIT];

    // ========================================
    // undervoltage response
    icr_pkg::icr_uv_e uv_sel;
    logic             uv_reset_req;
    logic             next_uv_irq;

    assign uv_sel = icr_pkg::icr_uv_e'(regulator_setup[`ICR_UV_SEL_LSB +: 2]);

    always_comb
    begin
        case (uv_sel)
            icr_pkg::ICR_UV_INT_HI:
            begin
                uv_reset_req = uv_below_lo_i;
                next_uv_irq  = uv_below_hi_i;
            end
            icr_pkg::ICR_UV_RST_LO:
            begin
                uv_reset_req = uv_below_lo_i;
                next_uv_irq  = 1'b0;
            end
            default:
            begin
                uv_reset_req = uv_below_hi_i;
                next_uv_irq  = 1'b0;
            end
        endcase
    end

    // ========================================
    // reset hold after recovery
    icr_pkg::icr_hold_e hold_st;
    icr_pkg::icr_hold_e next_hold_st;
    logic [CNT_W-1:0]   hold_cnt;
    logic [CNT_W-1:0]   next_hold_cnt;
    logic               next_rst_n;

    always_comb
    begin
        next_hold_st  = hold_st;
        next_hold_cnt = hold_cnt;
        next_rst_n    = 1'b0;
        case (hold_st)
            icr_pkg::ICR_HOLD_IDLE:
            begin
                if (!uv_reset_req)
                begin
                    next_hold_st  = icr_pkg::ICR_HOLD_COUNT;
                    next_hold_cnt = hold_len(regulator_setup[`ICR_HOLD_SEL_LSB +: 2]);
                end
            end
            icr_pkg::ICR_HOLD_COUNT:
            begin
                if (uv_reset_req)
                    next_hold_st = icr_pkg::ICR_HOLD_IDLE;
                else if (hold_cnt <= CNT_W'(1))
                begin
                    next_hold_st = icr_pkg::ICR_HOLD_DONE;
                    next_rst_n   = 1'b1;
                end
                else
                    next_hold_cnt = hold_cnt - CNT_W'(1);
            end
            icr_pkg::ICR_HOLD_DONE:
            begin
                next_rst_n = !uv_reset_req;
                if (uv_reset_req)
                    next_hold_st = icr_pkg::ICR_HOLD_IDLE;
            end
            default: next_hold_st = icr_pkg::ICR_HOLD_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            hold_st              <= icr_pkg::ICR_HOLD_IDLE;
            hold_cnt             <= '0;
            system_reset_out_n_o <= 1'b0;
            uv_irq_o             <= 1'b0;
        end
        else
        begin
            hold_st              <= next_hold_st;
            hold_cnt             <= next_hold_cnt;
            system_reset_out_n_o <= next_rst_n;
            uv_irq_o             <= next_uv_irq;
        end
    end

    // ========================================
    // cyclic sense activation
    logic [CNT_W-1:0] cyc_cnt;
    logic [CNT_W-1:0] next_cyc_cnt;
    logic             next_io0;
    logic             next_sample;

    always_comb
    begin
        next_cyc_cnt = cyc_cnt;
        if (!cyclic_en_i)
            next_cyc_cnt = '0;
        else if (cyclic_start_i && cyc_cnt == '0)
            next_cyc_cnt = cyc_len(regulator_setup[`ICR_CYC_SEL_LSB +: 2]);
        else if (cyc_cnt != '0)
            next_cyc_cnt = cyc_cnt - CNT_W'(1);
        next_io0 = (next_cyc_cnt != '0);
        // sync mode: the input is only meaningful while its partner drives
        if (cyclic_en_i && regulator_setup[`ICR_IO_SYNC_BIT])
            next_sample = wake_io_zero_o && wake_io_one_i;
        else
            next_sample = wake_io_one_i;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            cyc_cnt              <= '0;
            wake_io_zero_o       <= 1'b0;
            wake_io_one_sample_o <= 1'b0;
        end
        else
        begin
            cyc_cnt              <= next_cyc_cnt;
            wake_io_zero_o       <= next_io0;
            wake_io_one_sample_o <= next_sample;
        end
    end
endmodule : icr_init_config

/* File: core/icr_map.svh */
// register addresses, field positions, reset values and timing counts for the init config bank
// assumes a 5-bit register address taken from the command's first byte
`ifndef ICR_MAP_SVH
`define ICR_MAP_SVH

// ========================================
// addresses
`define ICR_ADDR_REG_SETUP     5'h05
`define ICR_ADDR_WDOG_SETUP    5'h06

// ========================================
// reset values
`define ICR_RST_REG_SETUP      8'h80
`define ICR_RST_WDOG_SETUP     8'h42
// fail_pin_second_pulse reset value is unspecified; taken as 0
`define ICR_RST_FAIL_PIN_2ND   1'b0

// ========================================
// regulator_setup fields
`define ICR_IO_SYNC_BIT        7
`define ICR_UV_SEL_LSB         5
`define ICR_HOLD_SEL_LSB       3
`define ICR_AUX_V_BIT          2
`define ICR_CYC_SEL_LSB        0

// ========================================
// watchdog_setup fields
`define ICR_IRQ_DL_BIT         7
`define ICR_MCU_OVERCURRENT_SEL_BIT         6
`define ICR_OVERCURRENT_TIMING_SEL_BIT         5
`define ICR_FAIL_2ND_BIT       4
`define ICR_WD_OP_LSB          2
`define ICR_WD_WIN_BIT         1
`define ICR_CRANK_BIT          0

// ========================================
// timing: clock period in ps, times taken as ns by ICR_US_TO_CYC (t * 1000 ps)
`define ICR_CLK_PS             5000
`define ICR_HOLD_0_US          1000
`define ICR_HOLD_1_US          5000
`define ICR_HOLD_2_US          10000
`define ICR_HOLD_3_US          20000
`define ICR_CYC_0_US           200
`define ICR_CYC_1_US           400
`define ICR_CYC_2_US           800
`define ICR_CYC_3_US           1600
`define ICR_US_TO_CYC(t)       (((t) * 1000) / `ICR_CLK_PS)

`endif

/* File: core/icr_pkg.sv */
// types shared by the init config bank
// assumes icr_map.svh for numbers
package icr_pkg;
    typedef enum logic [1:0] {
        ICR_UV_RST_HI  = 2'b00,
        ICR_UV_INT_HI  = 2'b01,
        ICR_UV_RST_LO  = 2'b10,
        ICR_UV_RST_HI2 = 2'b11
    } icr_uv_e;

    typedef enum logic [2:0] {
        ICR_HOLD_IDLE  = 3'b001,
        ICR_HOLD_COUNT = 3'b010,
        ICR_HOLD_DONE  = 3'b100
    } icr_hold_e;
endpackage : icr_pkg

/* File: verification/icr_host_model.sv */
// host model: builds 16-bit commands and presents them as decoded accesses
// assumes the bank's one-cycle write strobe and registered read data
`timescale 1ns/1ps
module icr_host_model (
    // clock
    input  wire logic       clk_sys_i,
    // decoded access
    output logic            reg_wr_o,
    output logic      [4:0] reg_addr_o,
    output logic      [7:0] reg_wdata_o,
    input  wire logic [7:0] reg_rdata_i
);
    logic [15:0] cmd;
    initial
    begin
        reg_wr_o    = 1'b0;
        reg_addr_o  = 5'h1f;
        reg_wdata_o = 8'h00;
    end
    task automatic put(input logic wr, input logic [4:0] a, input logic [7:0] d);
        cmd = {1'b0, wr, a, 1'b0, d};
        @(posedge clk_sys_i);
        reg_wr_o    <= cmd[14];
        reg_addr_o  <= cmd[13:9];
        reg_wdata_o <= cmd[7:0];
        @(posedge clk_sys_i);
        reg_wr_o    <= 1'b0;
    endtask : put
    task automatic get(input logic [4:0] a, output logic [7:0] d);
        put(1'b0, a, 8'h00);
        // address still stands; data registered at the previous edge
        @(posedge clk_sys_i);
        d = reg_rdata_i;
    endtask : get
endmodule : icr_host_model

/* File: verification/icr_init_config_props.sv */
// checker for the init config bank
// assumes shortened counts of at least 10 hold and 8 cyclic cycles
`timescale 1ns/1ps
module icr_init_config_chk (
    // clock and reset
    input wire logic       clk_sys_i,
    input wire logic       rst_i,
    // register access
    input wire logic       init_mode_i,
    input wire logic       reg_wr_i,
    input wire logic [4:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic       reg_hit_o,
    // monitors and outputs
    input wire logic       uv_below_hi_i,
    input wire logic       uv_below_lo_i,
    input wire logic       uv_irq_o,
    input wire logic       system_reset_out_n_o,
    input wire logic       wake_io_zero_o,
    input wire logic       aux_supply_5v_o,
    input wire logic [7:0] watchdog_setup_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    logic [7:0] shadow;
    logic       req;
    // ========================================
    // shadow of regulator_setup, fed only by accepted writes
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
            shadow <= 8'h80;
        else if (reg_wr_i && init_mode_i && reg_addr_i == 5'h05)
            shadow <= reg_wdata_i;
    end
    assign req = (shadow[6:5] == 2'b01 || shadow[6:5] == 2'b10) ? uv_below_lo_i : uv_below_hi_i;
    sequence s_wr_wdog;
        reg_wr_i && init_mode_i && reg_addr_i == 5'h06;
    endsequence
    sequence s_wr_locked;
        reg_wr_i && !init_mode_i;
    endsequence
    // ========================================
    // assertions
    a_wdog_write_taken: assert property (s_wr_wdog |=> watchdog_setup_o == $past(reg_wdata_i))
        else $error("watchdog_setup write lost");
    a_locked_write_held: assert property (s_wr_locked |=> $stable(watchdog_setup_o) && $stable(aux_supply_5v_o))
        else $error("write outside init mode took effect");
    a_hit_decode: assert property (reg_hit_o == (reg_addr_i == 5'h05 || reg_addr_i == 5'h06))
        else $error("address decode wrong");
    a_unmapped_zero: assert property (!reg_hit_o |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_irq_level: assert property (1'b1 |=> uv_irq_o == $past(shadow[6:5] == 2'b01 && uv_below_hi_i))
        else $error("undervoltage interrupt wrong");
    a_reset_follows: assert property (req [*2] |=> !system_reset_out_n_o)
        else $error("reset not asserted on undervoltage");
    a_hold_minimum: assert property ($fell(req) |-> !system_reset_out_n_o [*8])
        else $error("reset released too early");
    a_wake_min_len: assert property ($rose(wake_io_zero_o) |-> wake_io_zero_o [*8])
        else $error("activation too short");
endmodule : icr_init_config_chk

bind icr_init_config icr_init_config_chk i_chk (.clk_sys_i, .rst_i, .init_mode_i, .reg_wr_i, .reg_addr_i,
    .reg_wdata_i, .reg_rdata_o, .reg_hit_o, .uv_below_hi_i, .uv_below_lo_i, .uv_irq_o, .system_reset_out_n_o,
    .wake_io_zero_o, .aux_supply_5v_o, .watchdog_setup_o);

/* File: verification/tb_icr_init_config.sv */
// bench for the init config bank with shortened hold and cyclic counts
// assumes the host model and the bound checker
`timescale 1ns/1ps
module tb_icr_init_config;
    localparam int H [4] = '{10, 20, 30, 40};
    localparam int C [4] = '{8, 16, 24, 32};
    logic       clk_sys_i, rst_i, init_mode_i, reg_wr_i, reg_hit_o, cyc_en, cyc_go, io1, io0, smp;
    logic       uv_hi, uv_lo, uv_irq_o, rst_n, aux_o;
    logic [4:0] reg_addr_i;
    logic [7:0] reg_wdata_i, reg_rdata_o, wd_o, d;
    int         num_errors, n_tests, n;
    icr_host_model i_icr_host_model (.clk_sys_i(clk_sys_i), .reg_wr_o(reg_wr_i), .reg_addr_o(reg_addr_i),
        .reg_wdata_o(reg_wdata_i), .reg_rdata_i(reg_rdata_o));
    icr_init_config #(.HOLD_0_CYC(H[0]), .HOLD_1_CYC(H[1]), .HOLD_2_CYC(H[2]), .HOLD_3_CYC(H[3]),
        .CYC_0_CYC(C[0]), .CYC_1_CYC(C[1]), .CYC_2_CYC(C[2]), .CYC_3_CYC(C[3]))
        i_icr_init_config (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .init_mode_i(init_mode_i), .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .reg_hit_o(reg_hit_o), .cyclic_en_i(cyc_en), .cyclic_start_i(cyc_go),
        .wake_io_one_i(io1), .wake_io_zero_o(io0), .wake_io_one_sample_o(smp), .uv_below_hi_i(uv_hi),
        .uv_below_lo_i(uv_lo), .uv_irq_o(uv_irq_o), .system_reset_out_n_o(rst_n), .aux_supply_5v_o(aux_o),
        .watchdog_setup_o(wd_o));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            num_errors++;
        end
    endtask : chk
    task automatic rd(input logic [4:0] a, input logic [7:0] exp);
        i_icr_host_model.get(a, d);
        chk(d, exp);
    endtask : rd
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_sys_i);
    endtask : cyc
    task automatic give_verdict;
        if (num_errors == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict
    initial
    begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end
    initial
    begin
        // the whole sequence needs well under 3000 cycles
        repeat (20000) @(posedge clk_sys_i);
        num_errors++;
        give_verdict();
    end
    initial
    begin
        {rst_i, init_mode_i, cyc_en, cyc_go, io1, uv_hi, uv_lo} <= 7'b1000000;
        cyc(20);
        rst_i <= 1'b0;
        rd(5'h05, 8'h80);
        rd(5'h06, 8'h42);
        chk(reg_hit_o, 1'b1);
        rd(5'h07, 8'h00);
        chk(reg_hit_o, 1'b0);
        i_icr_host_model.put(1'b1, 5'h05, 8'h1F);
        rd(5'h05, 8'h80);
        i_icr_host_model.put(1'b1, 5'h06, 8'h00);
        rd(5'h06, 8'h42);
        init_mode_i <= 1'b1;
        i_icr_host_model.put(1'b1, 5'h06, 8'hB5);
        rd(5'h06, 8'hB5);
        chk(wd_o, 8'hB5);
        i_icr_host_model.put(1'b1, 5'h05, 8'h04);
        rd(5'h05, 8'h04);
        chk(aux_o, 1'b1);
        for (int c = 0; c < 4; c++)
        begin
            // interrupt and reset per code, then the hold time per selection
            i_icr_host_model.put(1'b1, 5'h05, {1'b0, c[1:0], c[1:0], 3'b000});
            uv_hi <= 1'b1;
            cyc(4);
            chk(aux_o, 1'b0);
            chk(uv_irq_o, c == 1);
            chk(rst_n, c == 1 || c == 2);
            uv_lo <= 1'b1;
            cyc(4);
            chk(rst_n, 1'b0);
            {uv_hi, uv_lo} <= 2'b00;
            cyc(1);
            for (n = 0; rst_n !== 1'b1 && n < 200; n++)
                cyc(1);
            chk(n >= H[c] && n <= H[c] + 2, 1'b1);
        end
        cyc_en <= 1'b1;
        for (int k = 0; k < 4; k++)
        begin
            i_icr_host_model.put(1'b1, 5'h05, {6'b0, k[1:0]});
            cyc_go <= 1'b1;
            cyc(1);
            cyc_go <= 1'b0;
            for (n = 0; io0 !== 1'b1 && n < 5; n++)
                cyc(1);
            for (n = 0; io0 === 1'b1 && n < 100; n++)
                cyc(1);
            chk(n, C[k]);
        end
        i_icr_host_model.put(1'b1, 5'h05, 8'h80);
        io1 <= 1'b1;
        cyc(6);
        chk(smp, 1'b0);
        cyc_go <= 1'b1;
        cyc(1);
        cyc_go <= 1'b0;
        cyc(4);
        chk(smp, 1'b1);
        cyc(10);
        i_icr_host_model.put(1'b1, 5'h05, 8'h00);
        cyc(4);
        chk(smp, 1'b1);
        give_verdict();
    end
endmodule : tb_icr_init_config
